// *** include/result_regs_pkg.sv ***
// result register package: offsets, reset values, carriers, decode helpers
// assumes a 16-bit register address space as seen by the serial register port

package result_regs_pkg;

   // ==========================================================================
   // register offsets, as printed
   localparam logic [15:0] ADDR_DIE_TEMPERATURE = 16'h0110; // temperature code
   localparam logic [15:0] ADDR_CELL1_Z_FIELD   = 16'h0111; // cell 1, z field
   localparam logic [15:0] ADDR_CELL0_Z_FIELD   = 16'h0112; // cell 0, z field
   localparam logic [15:0] ADDR_CELL1_X_FIELD   = 16'h0113; // cell 1, x field
   localparam logic [15:0] ADDR_CELL0_X_FIELD   = 16'h0114; // cell 0, x field
   localparam int          RESULT_COUNT         = 5;        // words in the block

   // ==========================================================================
   // field layout and reset values
   localparam int          WORD_WIDTH      = 16;     // every result is 16 bits
   localparam int          TEMPERATURE_MSB = 15;     // temperature_msb position
   localparam int          TEMPERATURE_LSB = 0;      // temperature_lsb position
   localparam logic [15:0] RESULT_RESET    = 16'h0000; // no measurement yet
   localparam logic [15:0] READ_IDLE       = 16'h0000; // unmapped address reads
   localparam logic        DONE_RESET      = 1'b0;   // calculating after reset
   // celsius = code / TEMP_DIVISOR + TEMP_OFFSET_C, code taken as unsigned
   localparam int          TEMP_DIVISOR    = 200;
   localparam int          TEMP_OFFSET_C   = 25;

   typedef logic [WORD_WIDTH-1:0] word_t;

   // ==========================================================================
   // carriers
   typedef struct packed {
      word_t die_temperature_reading; // raw temperature code
      word_t cell1_z_field;           // z field of cell 1
      word_t cell0_z_field;           // z field of cell 0
      word_t cell1_x_field;           // x field of cell 1
      word_t cell0_x_field;           // x field of cell 0
   } result_set_s;

   // one-hot measurement phase
   typedef enum logic [1:0] {
      PHASE_CALC = 2'b01,             // calculation in progress
      PHASE_DONE = 2'b10              // fresh results stored
   } phase_e;

   // ==========================================================================
   // one-hot select of a result word, zero when the address is unmapped
   function automatic logic [RESULT_COUNT-1:0] result_select(input logic [15:0] addr);
      logic [RESULT_COUNT-1:0] sel;
      sel = '0;
      if (addr == ADDR_DIE_TEMPERATURE) sel[0] = 1'b1;
      if (addr == ADDR_CELL1_Z_FIELD)   sel[1] = 1'b1;
      if (addr == ADDR_CELL0_Z_FIELD)   sel[2] = 1'b1;
      if (addr == ADDR_CELL1_X_FIELD)   sel[3] = 1'b1;
      if (addr == ADDR_CELL0_X_FIELD)   sel[4] = 1'b1;
      return sel;
   endfunction

   // result word by select index, in address order
   function automatic word_t result_word(input result_set_s r, input int idx);
      word_t w;
      w = READ_IDLE;
      case (idx)
         0:       w = r.die_temperature_reading;
         1:       w = r.cell1_z_field;
         2:       w = r.cell0_z_field;
         3:       w = r.cell1_x_field;
         4:       w = r.cell0_x_field;
         default: w = READ_IDLE;
      endcase
      return w;
   endfunction

endpackage

// *** core/result_read_port.sv ***
// read side of the result registers: address decode and registered read data
// assumes strobe and address come from the serial register port, same clock

`timescale 1ns/1ns

module result_read_port
   import result_regs_pkg::*;
(
   input  wire logic        i_clock,     // measurement clock
   input  wire logic        i_rst_b,     // async reset, active low
   input  wire logic        i_rd_strobe, // one-cycle read request
   input  wire logic [15:0] i_addr,      // register address
   input  wire result_set_s i_results,   // held result words
   output logic [15:0]      o_rd_data,   // read data, registered
   output logic             o_rd_valid,  // read answer pulse
   output logic             o_rd_hit     // address belonged to this block
);

   // ==========================================================================
   // state
   typedef struct packed {
      word_t rd_data;  // captured word
      logic  rd_valid; // answer marker
      logic  rd_hit;   // mapped address marker
   } read_state_s;

   read_state_s state_reg;  // registered state
   read_state_s state_next; // next state

   // decode and mux; unmapped addresses read as zero
   always_comb begin
      logic [RESULT_COUNT-1:0] sel;
      sel                 = result_select(i_addr);
      state_next          = state_reg;
      state_next.rd_valid = i_rd_strobe;
      if (i_rd_strobe) begin
         // reading only samples, it never touches the stored words
         state_next.rd_data = READ_IDLE;
         state_next.rd_hit  = |sel;
         for (int i = 0; i < RESULT_COUNT; i++) begin
            if (sel[i]) begin
               state_next.rd_data = result_word(i_results, i);
            end
         end
      end
   end

   // register the copy
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= '{rd_data: READ_IDLE, rd_valid: 1'b0, rd_hit: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rd_data  = state_reg.rd_data;
   assign o_rd_valid = state_reg.rd_valid;
   assign o_rd_hit   = state_reg.rd_hit;

   // ==========================================================================
   // checks
   a_temp_read_word: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && i_addr == ADDR_DIE_TEMPERATURE |=>
      o_rd_valid && o_rd_hit && o_rd_data == $past(i_results.die_temperature_reading))
      else $error("temperature read returned wrong word");

   a_cell0_x_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && i_addr == ADDR_CELL0_X_FIELD |=>
      o_rd_data == $past(i_results.cell0_x_field))
      else $error("cell 0 x field read returned wrong word");

   a_unmapped_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && result_select(i_addr) == '0 |=>
      o_rd_valid && !o_rd_hit && o_rd_data == READ_IDLE)
      else $error("unmapped read not answered with zero");

endmodule

// *** core/measurement_result_registers.sv ***
// measurement result registers: temperature and four hall field words
// assumes the measurement sequencer and the register port share i_clock
// assumes loads and starts arrive from the sequencer as one-cycle pulses

`timescale 1ns/1ns

module measurement_result_registers
   import result_regs_pkg::*;
(
   input  wire logic        i_clock,      // measurement clock, 100 MHz
   input  wire logic        i_rst_b,      // async reset, active low
   input  wire logic        i_calc_start, // pulse: new calculation begins
   input  wire logic        i_meas_load,  // pulse: cycle complete, results valid
   input  wire result_set_s i_meas,       // results from the sequencer
   input  wire logic        i_rd_strobe,  // pulse: host register read
   input  wire logic        i_wr_strobe,  // pulse: host register write
   input  wire logic [15:0] i_addr,       // register address
   input  wire logic [15:0] i_wr_data,    // write data, never stored here
   output logic             o_meas_done,  // measurement-done status flag
   output logic [15:0]      o_rd_data,    // read data, registered
   output logic             o_rd_valid,   // read answer pulse
   output logic             o_rd_hit,     // read address was a result word
   output logic             o_wr_refused  // write to a result word was dropped
);

   // ==========================================================================
   // state
   typedef struct packed {
      phase_e      phase;      // calc or done
      result_set_s results;    // held result words
      logic        wr_refused; // dropped write marker
   } core_state_s;

   core_state_s state_reg;  // registered state
   core_state_s state_next; // next state

   // write data is deliberately unused; the words are read-only
   logic [15:0] wr_data_unused;
   assign wr_data_unused = i_wr_data;

   // ==========================================================================
   // next state
   always_comb begin
      // default: every word and the phase hold until an event moves them
      state_next = state_reg;
      // a write aimed at a result word is swallowed, only flagged
      state_next.wr_refused = i_wr_strobe && (|result_select(i_addr));

      // phase steps: calc until a load, done until a start without a load
      unique case (state_reg.phase)
         PHASE_CALC: begin
            // flag reads zero while calculating
            if (i_meas_load) begin
               state_next.phase = PHASE_DONE;
            end
         end
         PHASE_DONE: begin
            // a load in the same cycle as a new start wins, so no result is lost
            if (i_calc_start && !i_meas_load) begin
               state_next.phase = PHASE_CALC;
            end
         end
      endcase

      // whole set loads at once so a host never sees a mixed cycle
      if (i_meas_load) begin
         state_next.results.die_temperature_reading =
            i_meas.die_temperature_reading;
         state_next.results.cell1_z_field = i_meas.cell1_z_field;
         state_next.results.cell0_z_field = i_meas.cell0_z_field;
         state_next.results.cell1_x_field = i_meas.cell1_x_field;
         state_next.results.cell0_x_field = i_meas.cell0_x_field;
      end
   end

   // ==========================================================================
   // register the copy; results start at zero until the first cycle ends
   // no clock enable: the copy is taken on every edge, so a word that must
   // hold is simply carried forward by the next-state block
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg.phase      <= PHASE_CALC;
         state_reg.results    <= {RESULT_COUNT{RESULT_RESET}};
         state_reg.wr_refused <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_meas_done  = (state_reg.phase == PHASE_DONE);
   assign o_wr_refused = state_reg.wr_refused;

   // ==========================================================================
   // read port
   // the port reads the registered set only, so a read in the load cycle
   // returns the previous word and never a half-updated mix
   result_read_port u_read_port (
      .i_clock     (i_clock),
      .i_rst_b     (i_rst_b),
      .i_rd_strobe (i_rd_strobe),
      .i_addr      (i_addr),
      .i_results   (state_reg.results),
      .o_rd_data   (o_rd_data),
      .o_rd_valid  (o_rd_valid),
      .o_rd_hit    (o_rd_hit)
   );

   // ==========================================================================
   // checks
   // every check is cut off while reset is low, so the async clear never trips them
   sequence s_cycle_end;
      i_meas_load;
   endsequence

   sequence s_write_hit;
      i_wr_strobe && (|result_select(i_addr)) && !i_meas_load;
   endsequence

   // a start that no load overrides: apart from reset, the only way the done flag falls
   sequence s_restart;
      i_calc_start && !i_meas_load;
   endsequence

   // a host read of any mapped word
   sequence s_read_hit;
      i_rd_strobe && (|result_select(i_addr));
   endsequence

   a_temp_loads: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end |=> state_reg.results.die_temperature_reading
                      == $past(i_meas.die_temperature_reading))
      else $error("temperature not loaded at cycle end");

   a_cell1_z_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end |=> state_reg.results.cell1_z_field == $past(i_meas.cell1_z_field))
      else $error("cell 1 z field not loaded");

   a_cell0_z_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end |=> state_reg.results.cell0_z_field == $past(i_meas.cell0_z_field))
      else $error("cell 0 z field not loaded");

   a_cell1_x_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_meas_load ##1 i_rd_strobe && i_addr == ADDR_CELL1_X_FIELD |=>
      o_rd_data == $past(i_meas.cell1_x_field, 2))
      else $error("cell 1 x field not readable after load");

   a_cell0_x_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end |=> state_reg.results.cell0_x_field == $past(i_meas.cell0_x_field))
      else $error("cell 0 x field not loaded");

   a_done_on_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end |=> o_meas_done)
      else $error("done flag not set at cycle end");

   a_done_clears: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_restart |=> !o_meas_done)
      else $error("done flag still set while calculating");

   a_write_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_write_hit |=> $stable(state_reg.results) && o_wr_refused)
      else $error("write altered a result word");

   a_hold_between: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_meas_load |=> $stable(state_reg.results))
      else $error("results changed without a cycle end");

   // ==========================================================================
   // read answers for the words the port checks leave out
   // the port samples the registered set, so a load in the strobe cycle is not seen yet
   a_cell1_z_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && i_addr == ADDR_CELL1_Z_FIELD |=>
      o_rd_hit && o_rd_data == $past(state_reg.results.cell1_z_field))
      else $error("cell 1 z field read returned wrong word");

   a_cell0_z_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && i_addr == ADDR_CELL0_Z_FIELD |=>
      o_rd_hit && o_rd_data == $past(state_reg.results.cell0_z_field))
      else $error("cell 0 z field read returned wrong word");

   a_cell1_x_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd_strobe && i_addr == ADDR_CELL1_X_FIELD |=>
      o_rd_hit && o_rd_data == $past(state_reg.results.cell1_x_field))
      else $error("cell 1 x field read returned wrong word");

   // every mapped strobe gets its answer pulse one cycle later
   a_read_answer: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_read_hit |=> o_rd_valid && o_rd_hit)
      else $error("mapped read not answered");

   // between strobes the answer lines stand still; a read has no side effect
   a_no_stray_answer: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_rd_strobe |=> !o_rd_valid && $stable(o_rd_data) && $stable(o_rd_hit))
      else $error("read port moved without a strobe");

   // ==========================================================================
   // done flag bookkeeping
   // a start and a load in one cycle leave the flag set, so no result is lost
   a_set_wins: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      s_cycle_end ##0 i_calc_start |=> o_meas_done)
      else $error("done flag lost when start met a load");

   a_done_holds: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_meas_done && !i_calc_start |=> o_meas_done)
      else $error("done flag dropped without a new calculation");

   a_calc_holds: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !o_meas_done && !i_meas_load |=> !o_meas_done)
      else $error("done flag set without a cycle end");

   // ==========================================================================
   // host writes
   // a refusal pulse only ever follows a write to a mapped word
   a_refuse_only_hit: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !(i_wr_strobe && (|result_select(i_addr))) |=> !o_wr_refused)
      else $error("write refusal flagged without a mapped write");

   // the status side is untouched by any write
   a_write_keeps_done: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_wr_strobe && !i_meas_load && !i_calc_start |=> $stable(o_meas_done))
      else $error("write changed the done flag");

endmodule

// *** sim/host_model.sv ***
// host model: issues register reads and writes on the serial register port
// assumes one clock shared with the device; drives just after the rising edge

`timescale 1ns/1ns

module host_model (
   input  wire logic        i_clock,     // shared clock
   output logic             o_rd_strobe, // read request pulse
   output logic             o_wr_strobe, // write request pulse
   output logic [15:0]      o_addr,      // register address
   output logic [15:0]      o_wr_data    // write data
);
   // ==========================================================================
   // idle values at time zero
   initial begin
      o_rd_strobe = 1'b0;
      o_wr_strobe = 1'b0;
      o_addr      = 16'h0000;
      o_wr_data   = 16'h0000;
   end

   // ==========================================================================
   // one read request; kept up by the next call so reads run back to back
   task automatic rd(input logic [15:0] a);
      @(posedge i_clock);
      o_rd_strobe <= 1'b1;
      o_wr_strobe <= 1'b0;
      o_addr      <= a;
   endtask

   // one write request
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clock);
      o_wr_strobe <= 1'b1;
      o_rd_strobe <= 1'b0;
      o_addr      <= a;
      o_wr_data   <= d;
   endtask

   // release: lines invert so a stale address never looks valid
   task automatic idle();
      @(posedge i_clock);
      o_rd_strobe <= 1'b0;
      o_wr_strobe <= 1'b0;
      o_addr      <= ~o_addr;
      o_wr_data   <= ~o_wr_data;
   endtask
endmodule

// *** sim/tb_top.sv ***
// testbench: loads results, reads and writes them through the host model
// assumes the result block and host model share one 100 MHz clock

`timescale 1ns/1ns

module tb_top;
   import result_regs_pkg::*;
   logic        i_clock, i_rst_b, i_calc_start, i_meas_load;
   logic        rd_s, wr_s, o_meas_done, o_rd_valid, o_rd_hit, o_wr_refused;
   logic [15:0] addr, wdata, o_rd_data;
   result_set_s i_meas, exp_r, v;       // drive value and expected contents
   logic [16:0] exp_q[$];               // expected {hit, data} per read
   logic [16:0] e;                      // oldest note
   logic [95:0] t;                      // random scratch
   int          n_fail, n_tests, n_refused, cycles, seed;
   // unmapped neighbours on both ends of the map
   localparam logic [15:0] ADDRS [7] = '{16'h010F, ADDR_DIE_TEMPERATURE,
      ADDR_CELL1_Z_FIELD, ADDR_CELL0_Z_FIELD, ADDR_CELL1_X_FIELD,
      ADDR_CELL0_X_FIELD, 16'h0115};

   host_model i_host_model (.i_clock(i_clock), .o_rd_strobe(rd_s), .o_wr_strobe(wr_s),
      .o_addr(addr), .o_wr_data(wdata));
   measurement_result_registers i_measurement_result_registers (.i_clock(i_clock),
      .i_rst_b(i_rst_b), .i_calc_start(i_calc_start), .i_meas_load(i_meas_load),
      .i_meas(i_meas), .i_rd_strobe(rd_s), .i_wr_strobe(wr_s), .i_addr(addr),
      .i_wr_data(wdata), .o_meas_done(o_meas_done), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit), .o_wr_refused(o_wr_refused));

   // ==========================================================================
   // clock and cycle ceiling
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin           // far above the roughly 130 needed
         n_fail++;
         wrap_up();
      end
   end

   // ==========================================================================
   // helpers
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
      n_tests++;
      if (seen !== ex) begin
         n_fail++;
         $display("Error: %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   function automatic logic [16:0] expect_rd(input logic [15:0] a);
      case (a)
         ADDR_DIE_TEMPERATURE: return {1'b1, exp_r.die_temperature_reading};
         ADDR_CELL1_Z_FIELD:   return {1'b1, exp_r.cell1_z_field};
         ADDR_CELL0_Z_FIELD:   return {1'b1, exp_r.cell0_z_field};
         ADDR_CELL1_X_FIELD:   return {1'b1, exp_r.cell1_x_field};
         ADDR_CELL0_X_FIELD:   return {1'b1, exp_r.cell0_x_field};
         default:              return {1'b0, READ_IDLE};  // unmapped reads zero
      endcase
   endfunction
   // back-to-back reads of the whole map plus both neighbours
   task automatic read_all(input string nm);
      for (int i = 0; i < 7; i++) begin
         i_host_model.rd(ADDRS[i]);
         exp_q.push_back(expect_rd(ADDRS[i]));
      end
      i_host_model.idle();
      repeat (3) @(posedge i_clock);
      check("queue_empty", 16'(exp_q.size()), 16'h0000);
      $display("test %s done", nm);
   endtask
   // load a result set; start may coincide to test set over clear
   task automatic load(input result_set_s r, input logic st);
      @(posedge i_clock);
      i_meas_load  <= 1'b1;
      i_calc_start <= st;
      i_meas       <= r;
      exp_r         = r;
      @(posedge i_clock);
      i_meas_load  <= 1'b0;
      i_calc_start <= 1'b0;
      i_meas       <= ~r;                 // data no longer valid
      #1 check("meas_done", {15'h0, o_meas_done}, 16'h0001);
   endtask
   task automatic do_reset();
      i_rst_b <= 1'b0;
      exp_r    = {RESULT_COUNT{RESULT_RESET}};
      repeat (20) @(posedge i_clock);
      i_rst_b <= 1'b1;
      @(posedge i_clock);
      #1 check("meas_done", {15'h0, o_meas_done}, {15'h0, DONE_RESET});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================================
   // watcher: every read answer takes the oldest note
   always @(posedge i_clock) begin
      if (o_rd_valid === 1'b1) begin
         e = exp_q.size() ? exp_q.pop_front() : 17'h1FFFF; // stray answer fails
         check("rd_data", o_rd_data, e[15:0]);
         check("rd_hit", {15'h0, o_rd_hit}, {15'h0, e[16]});
      end
      if (o_wr_refused === 1'b1)
         n_refused++;
   end

   // ==========================================================================
   // main sequence
   initial begin
      {i_rst_b, i_calc_start, i_meas_load} = 3'b000;
      i_meas = '0;
      seed   = $urandom(18);
      do_reset();
      read_all("reset_values");
      t = {$urandom(), $urandom(), $urandom()};
      v = t[79:0];
      load(v, 1'b0);
      read_all("load_and_map");
      for (int i = 0; i < 7; i++)
         i_host_model.wr(ADDRS[i], 16'($urandom()));
      i_host_model.idle();
      repeat (2) @(posedge i_clock);
      check("refusals", 16'(n_refused), 16'(RESULT_COUNT));
      read_all("writes_ignored");
      @(posedge i_clock);
      i_calc_start <= 1'b1;
      @(posedge i_clock);
      i_calc_start <= 1'b0;
      #1 check("meas_done", {15'h0, o_meas_done}, 16'h0000);
      read_all("held_while_calc");
      v.die_temperature_reading = 16'h07D0; // 2000: 35 C by code/200+25
      fork                                 // read the fresh set right behind the load
         load(v, 1'b1);
         begin
            @(posedge i_clock);
            i_host_model.rd(ADDR_CELL1_X_FIELD);
            exp_q.push_back(expect_rd(ADDR_CELL1_X_FIELD));
            i_host_model.rd(ADDR_DIE_TEMPERATURE);
            exp_q.push_back(expect_rd(ADDR_DIE_TEMPERATURE));
            i_host_model.idle();
         end
      join
      @(posedge i_clock);
      #1 check("celsius", 16'(int'(o_rd_data) / TEMP_DIVISOR + TEMP_OFFSET_C),
         16'h0023);
      $display("test celsius_read done");
      load(v, 1'b1);                       // start while done: set wins
      read_all("temperature_set_wins");
      do_reset();
      read_all("second_reset");
      wrap_up();
   end
endmodule
